// ===== hw/sfs_ctrl.sv
// Purpose: Serial programming, configuration latches and output steering of a clock synthesizer
// Assumes: Frame select, shift clock, serial data and the drive-enable pin are asynchronous;
//          the oscillator and reference levels come from logic on ref_clk_i
// Notes:   Shift clock high and low phases must each span at least three ref_clk_i periods
`timescale 1ns/1ps

module sfs_ctrl #(
    parameter bit          PRESET_VARIANT_B = 1'b0,
    parameter int unsigned SETTLE_CYCLES    = sfs_pkg::SETTLE_CYCLES
) (
    input  wire logic                          ref_clk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          frame_select_n_i,
    input  wire logic                          shift_clock_i,
    input  wire logic                          serial_data_in_i,
    input  wire logic                          output_drive_enable_pin_i,
    input  wire logic                          osc_level_i,
    input  wire logic                          ref_level_i,
    output sfs_pkg::sfs_cfg_s                  cfg_o,
    output logic                               commit_o,
    output logic                               frame_active_o,
    output logic [sfs_pkg::CNT_W-1:0]          bit_count_o,
    output logic                               settle_busy_o,
    output logic                               main_output_o,
    output logic                               main_output_oe_n_o,
    output logic                               divided_output_o,
    output logic                               divided_output_oe_n_o
);
    localparam logic [sfs_pkg::WORD_W-1:0] PRESET_WORD =
        PRESET_VARIANT_B ? sfs_pkg::PRESET_WORD_B : sfs_pkg::PRESET_WORD_A;
    localparam logic [sfs_pkg::SETTLE_W-1:0] SETTLE_LOAD = sfs_pkg::SETTLE_W'(SETTLE_CYCLES);

    // Pin synchronisers: stage one feeds stage two only
    logic [1:0] cs_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] oe_sync_reg;
    logic       sclk_prev_reg;
    logic       cs_prev_reg;

    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic oe_pin_s;
    logic sclk_rise;
    logic cs_fall;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_sync_reg   <= 2'h3;
            sclk_sync_reg <= 2'h0;
            sdi_sync_reg  <= 2'h0;
            oe_sync_reg   <= 2'h0;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], frame_select_n_i};
            sclk_sync_reg <= {sclk_sync_reg[0], shift_clock_i};
            sdi_sync_reg  <= {sdi_sync_reg[0], serial_data_in_i};
            oe_sync_reg   <= {oe_sync_reg[0], output_drive_enable_pin_i};
            sclk_prev_reg <= sclk_sync_reg[1];
            cs_prev_reg   <= cs_sync_reg[1];
        end
    end

    assign cs_n_s    = cs_sync_reg[1];
    assign sclk_s    = sclk_sync_reg[1];
    assign sdi_s     = sdi_sync_reg[1];
    assign oe_pin_s  = oe_sync_reg[1];
    // Only shift clock edges advance the shifter, never the synthesized outputs
    assign sclk_rise = sclk_s && !sclk_prev_reg;
    assign cs_fall   = !cs_n_s && cs_prev_reg;

    // Serial framing state
    sfs_pkg::sfs_ser_e                 state_reg;
    sfs_pkg::sfs_ser_e                 state_next;
    logic [sfs_pkg::WORD_W-1:0]        shift_reg;
    logic [sfs_pkg::WORD_W-1:0]        shift_next;
    logic [sfs_pkg::CNT_W-1:0]         count_reg;
    logic [sfs_pkg::CNT_W-1:0]         count_next;
    logic [sfs_pkg::WORD_W-1:0]        latch_reg;
    logic [sfs_pkg::WORD_W-1:0]        latch_next;
    logic                              commit_reg;
    logic                              commit_next;
    logic [sfs_pkg::WORD_W-1:0]        shifted_word;

    // New bit enters at the top, so after 24 shifts the first bit sits at bit 0
    assign shifted_word = {sdi_s, shift_reg[sfs_pkg::WORD_W-1:1]};

    always_comb begin
        state_next  = state_reg;
        shift_next  = shift_reg;
        count_next  = count_reg;
        latch_next  = latch_reg;
        commit_next = 1'b0;
        case (state_reg)
            sfs_pkg::SER_IDLE: begin
                count_next = sfs_pkg::CNT_ZERO;
                // Armed only by an edge, but the select synchroniser resets high, so a select held low through reset still starts a frame
                if (cs_fall) begin
                    state_next = sfs_pkg::SER_SHIFT;
                end
            end
            sfs_pkg::SER_SHIFT: begin
                if (cs_n_s) begin
                    // Early release: partial word dropped, latches untouched
                    state_next = sfs_pkg::SER_IDLE;
                    count_next = sfs_pkg::CNT_ZERO;
                end else if (sclk_rise) begin
                    shift_next = shifted_word;
                    count_next = count_reg + sfs_pkg::CNT_ONE;
                    if (count_reg == sfs_pkg::FRAME_BITS - sfs_pkg::CNT_ONE) begin
                        // Whole word copied at once on the 24th edge
                        latch_next  = shifted_word;
                        commit_next = 1'b1;
                        state_next  = sfs_pkg::SER_DONE;
                    end
                end
            end
            sfs_pkg::SER_DONE: begin
                // Further data ignored until the select goes high again
                if (cs_n_s) begin
                    state_next = sfs_pkg::SER_IDLE;
                    count_next = sfs_pkg::CNT_ZERO;
                end
            end
            default: begin
                state_next = sfs_pkg::SER_IDLE;
                count_next = sfs_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg  <= sfs_pkg::SER_IDLE;
            shift_reg  <= '0;
            count_reg  <= sfs_pkg::CNT_ZERO;
            latch_reg  <= PRESET_WORD;
            commit_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            shift_reg  <= shift_next;
            count_reg  <= count_next;
            latch_reg  <= latch_next;
            commit_reg <= commit_next;
        end
    end

    // Field decode of the committed word
    sfs_pkg::sfs_cfg_s           cfg;
    logic [sfs_pkg::CODE_W-1:0]  vco_code;
    logic [sfs_pkg::CODE_W-1:0]  div_code;

    assign cfg      = sfs_pkg::sfs_cfg_s'(latch_reg);
    // Reference divider and prescale go out to the loop unchanged
    assign vco_code = {cfg.vco_output_divider_code_hi, cfg.vco_output_divider_code_lo};
    assign div_code = {cfg.divided_output_divider_code_hi,
                       cfg.divided_output_divider_code_lo};

    // Settle window after reset and after each commit
    logic [sfs_pkg::SETTLE_W-1:0] settle_reg;
    logic [sfs_pkg::SETTLE_W-1:0] settle_next;

    always_comb begin
        settle_next = settle_reg;
        if (commit_reg) begin
            settle_next = SETTLE_LOAD;
        end else if (settle_reg != '0) begin
            settle_next = settle_reg - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_reg <= SETTLE_LOAD;
        end else begin
            settle_reg <= settle_next;
        end
    end

    // Output clock path
    logic vco_div_clk;
    logic main_level;
    logic main_reg;
    logic main_next;
    logic main_oe_n_reg;
    logic main_oe_n_next;
    logic div_oe_n_reg;
    logic div_oe_n_next;

    sfs_clk_div u_vco_div (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .src_i     (osc_level_i),
        .code_i    (vco_code),
        .clk_o     (vco_div_clk)
    );

    // Bypass selects the raw reference in place of the divided oscillator
    assign main_level = cfg.ref_bypass ? ref_level_i : vco_div_clk;

    // Divided output follows main output, bypass included
    sfs_clk_div u_out_div (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .src_i     (main_reg),
        .code_i    (div_code),
        .clk_o     (divided_output_o)
    );

    always_comb begin
        main_next      = main_level;
        main_oe_n_next = !(oe_pin_s && cfg.main_output_enable_bit);
        div_oe_n_next  = !(oe_pin_s && cfg.divided_output_enable_bit);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_reg      <= 1'b0;
            main_oe_n_reg <= 1'b1;
            div_oe_n_reg  <= 1'b1;
        end else begin
            main_reg      <= main_next;
            main_oe_n_reg <= main_oe_n_next;
            div_oe_n_reg  <= div_oe_n_next;
        end
    end

    assign cfg_o                 = cfg;
    assign commit_o              = commit_reg;
    assign frame_active_o        = (state_reg == sfs_pkg::SER_SHIFT);
    assign bit_count_o           = count_reg;
    assign settle_busy_o         = (settle_reg != '0);
    assign main_output_o         = main_reg;
    assign main_output_oe_n_o    = main_oe_n_reg;
    assign divided_output_oe_n_o = div_oe_n_reg;
endmodule

// ===== hw/sfs_pkg.sv
// Purpose: Shared constants and types for the serial synthesizer control block
// Assumes: One 25 MHz clock; serial pins arrive asynchronously
// Notes:   Word layout is LSB first on the wire, bit 0 lands in fb_div[0]
package sfs_pkg;

    localparam int unsigned WORD_W       = 24;
    localparam int unsigned CNT_W        = 5;
    localparam int unsigned DIV_FIELD_W  = 7;
    localparam int unsigned CODE_W       = 2;
    localparam int unsigned DIVCNT_W     = 3;

    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

    // Preset words: the two variants differ only in bits 15 and 16
    localparam logic [WORD_W-1:0] PRESET_WORD_A = 24'hbd097f;
    localparam logic [WORD_W-1:0] PRESET_WORD_B = 24'hbc897f;

    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned SETTLE_TIME_US = 200;
    // Longest time, so the cycle count rounds down
    localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W       = 16;

    typedef struct packed {
        logic                   rsvd_hi;
        logic                   ref_bypass;
        logic                   rsvd_lo;
        logic                   divided_output_enable_bit;
        logic                   main_output_enable_bit;
        logic                   vco_output_divider_code_hi;
        logic                   vco_output_divider_code_lo;
        logic                   divided_output_divider_code_hi;
        logic                   divided_output_divider_code_lo;
        logic                   prescale_select;
        logic [DIV_FIELD_W-1:0] reference_divider;
        logic [DIV_FIELD_W-1:0] vco_feedback_divider;
    } sfs_cfg_s;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'b001,
        SER_SHIFT = 3'b010,
        SER_DONE  = 3'b100
    } sfs_ser_e;

    // Toggle mask for a divide-by-2^code counter
    function automatic logic [DIVCNT_W-1:0] half_mask(input logic [CODE_W-1:0] code);
        case (code)
            2'h2:    half_mask = 3'h1;
            2'h3:    half_mask = 3'h3;
            default: half_mask = 3'h0;
        endcase
    endfunction

endpackage

// ===== hw/sfs_clk_div.sv
// Purpose: Power-of-two divider for a clock seen as a level in the ref clock domain
// Assumes: src_i comes from logic on ref_clk_i and toggles no faster than every cycle
// Notes:   Code 0 passes the source through one flop; a code change may glitch
`timescale 1ns/1ps
module sfs_clk_div (
    input  wire logic                        ref_clk_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        src_i,
    input  wire logic [sfs_pkg::CODE_W-1:0]  code_i,
    output logic                             clk_o
);
    logic                          src_prev_reg;
    logic                          out_reg;
    logic                          out_next;
    logic [sfs_pkg::DIVCNT_W-1:0]  cnt_reg;
    logic [sfs_pkg::DIVCNT_W-1:0]  cnt_next;
    logic [sfs_pkg::DIVCNT_W-1:0]  mask;

    always_comb begin
        mask     = sfs_pkg::half_mask(code_i);
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (code_i == 2'h0) begin
            out_next = src_i;
        end else if (src_i && !src_prev_reg) begin
            cnt_next = cnt_reg + 3'h1;
            if ((cnt_reg & mask) == mask) begin
                out_next = !out_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_prev_reg <= 1'b0;
            cnt_reg      <= 3'h0;
            out_reg      <= 1'b0;
        end else begin
            src_prev_reg <= src_i;
            cnt_reg      <= cnt_next;
            out_reg      <= out_next;
        end
    end

    assign clk_o = out_reg;
endmodule

// ===== tb/sfs_ctrl_checker.sv
// Purpose: Concurrent checks on the serial control block ports
// Assumes: One ref_clk_i domain, arst_n_i active low
// Notes:   Output clock level checks wait three cycles after reset for the pipeline; the enable checks do not
`timescale 1ns/1ps
module sfs_ctrl_checker #(
    parameter int unsigned SETTLE_CYCLES = 20
) (
    input wire logic                 ref_clk_i,
    input wire logic                 arst_n_i,
    input wire logic                 frame_select_n_i,
    input wire logic                 shift_clock_i,
    input wire logic                 serial_data_in_i,
    input wire logic                 output_drive_enable_pin_i,
    input wire logic                 osc_level_i,
    input wire logic                 ref_level_i,
    input wire sfs_pkg::sfs_cfg_s    cfg_o,
    input wire logic                 commit_o,
    input wire logic                 frame_active_o,
    input wire logic [4:0]           bit_count_o,
    input wire logic                 settle_busy_o,
    input wire logic                 main_output_o,
    input wire logic                 main_output_oe_n_o,
    input wire logic                 divided_output_o,
    input wire logic                 divided_output_oe_n_o
);
    localparam int SC_MAX = SETTLE_CYCLES + 2;
    logic [1:0] up_reg;
    logic [1:0] up_next;
    always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            up_reg <= 2'h0;
        else
            up_reg <= up_next;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_COMMIT_AT_24: assert property (commit_o |-> bit_count_o == 5'h18 && $past(bit_count_o) == 5'h17)
        else $error("commit without the 24th bit");
    AST_COMMIT_PULSE: assert property (commit_o |=> !commit_o)
        else $error("commit longer than one cycle");
    AST_CFG_ATOMIC: assert property (!commit_o |-> $stable(cfg_o))
        else $error("configuration moved without commit");
    AST_ACTIVE_BELOW_24: assert property (frame_active_o |-> bit_count_o < 5'h18)
        else $error("frame active past 24 bits");
    AST_IDLE_COUNT: assert property (!frame_active_o |-> bit_count_o == 5'h00 || bit_count_o == 5'h18)
        else $error("stray bit count outside a frame");
    AST_COUNT_STEP: assert property ($changed(bit_count_o) |-> bit_count_o == $past(bit_count_o) + 5'h01 || bit_count_o == 5'h00)
        else $error("bit count jumped");
    AST_COUNT_GATED: assert property (bit_count_o > $past(bit_count_o) |-> $past(frame_active_o))
        else $error("bit taken outside a frame");
    AST_SETTLE: assert property (commit_o |=> settle_busy_o ##[1:SC_MAX] !settle_busy_o)
        else $error("settle window wrong");
    AST_MAIN_OE: assert property (!main_output_oe_n_o |-> $past(cfg_o.main_output_enable_bit) && $past(output_drive_enable_pin_i, 3))
        else $error("main output driven while disabled");
    AST_DIV_OE: assert property (!divided_output_oe_n_o |-> $past(cfg_o.divided_output_enable_bit) && $past(output_drive_enable_pin_i, 3))
        else $error("divided output driven while disabled");
    AST_BYPASS: assert property (up_reg == 2'h3 && cfg_o.ref_bypass && $past(cfg_o.ref_bypass) |-> main_output_o == $past(ref_level_i))
        else $error("bypass does not pass reference");
    AST_MAIN_CODE0: assert property (up_reg == 2'h3 && !cfg_o.ref_bypass && !cfg_o.vco_output_divider_code_hi && !cfg_o.vco_output_divider_code_lo && $stable(cfg_o) && cfg_o == $past(cfg_o, 2) |-> main_output_o == $past(osc_level_i, 2))
        else $error("main output not undivided oscillator");
    AST_DIV_CODE0: assert property (up_reg == 2'h3 && !cfg_o.divided_output_divider_code_hi && !cfg_o.divided_output_divider_code_lo && $stable(cfg_o) |-> divided_output_o == $past(main_output_o))
        else $error("divided output not following main");
endmodule

bind sfs_ctrl sfs_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.ref_clk_i, .arst_n_i, .frame_select_n_i,
    .shift_clock_i, .serial_data_in_i, .output_drive_enable_pin_i, .osc_level_i, .ref_level_i, .cfg_o, .commit_o,
    .frame_active_o, .bit_count_o, .settle_busy_o, .main_output_o, .main_output_oe_n_o, .divided_output_o,
    .divided_output_oe_n_o);

// ===== tb/sfs_host.sv
// Purpose: Host model driving frame select, shift clock and serial data
// Assumes: Changes land on ref_clk_i falling edges, four cycles per phase
// Notes:   Shift clock idles low between frames; released data is inverted
`timescale 1ns/1ps
module sfs_host (
    input  wire logic ref_clk_i,
    output logic      frame_select_n_o,
    output logic      shift_clock_o,
    output logic      serial_data_o
);
    initial begin
        frame_select_n_o = 1'b1;
        shift_clock_o = 1'b0;
        serial_data_o = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Pulses past 24 carry the inverted word so stray capture shows
    task automatic send(input logic [23:0] w, input int keep);
        int i;
        frame_select_n_o = 1'b0;
        wait_n(4);
        for (i = 0; i < keep; i++) begin
            serial_data_o = (i < 24) ? w[i] : ~w[i-24];
            wait_n(4);
            shift_clock_o = 1'b1;
            wait_n(4);
            shift_clock_o = 1'b0;
        end
        wait_n(4);
        frame_select_n_o = 1'b1;
        serial_data_o = ~serial_data_o;
        wait_n(6);
    endtask
endmodule

// ===== tb/serial_freq_synth_control_bench.sv
// Purpose: Self-checking bench for the serial synthesizer control block
// Assumes: Inputs change on falling edges; short settle count
// Notes:   Random frames plus short, long and empty frames
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); end end
module serial_freq_synth_control_bench;
    logic              clk, arst_n, pin, osc, refl, cs_n, sclk, sdata;
    logic              commit, active, busy, mo, mo_oe_n, dvo, dvo_oe_n;
    logic              mo_q, dvo_q;
    logic [1:0]        rdiv;
    logic [4:0]        bit_count;
    logic [23:0]       cfg_w, exp_w, w;
    logic [31:0]       rng;
    sfs_pkg::sfs_cfg_s cfg_o;
    int                fails, n_checks, commits, cycles, c0, i, keep, mr, dr;
    assign cfg_w = cfg_o;
    sfs_host host (.ref_clk_i(clk), .frame_select_n_o(cs_n), .shift_clock_o(sclk), .serial_data_o(sdata));
    sfs_ctrl #(.SETTLE_CYCLES(20)) dut (.ref_clk_i(clk), .arst_n_i(arst_n), .frame_select_n_i(cs_n),
        .shift_clock_i(sclk), .serial_data_in_i(sdata), .output_drive_enable_pin_i(pin), .osc_level_i(osc),
        .ref_level_i(refl), .cfg_o(cfg_o), .commit_o(commit), .frame_active_o(active), .bit_count_o(bit_count),
        .settle_busy_o(busy), .main_output_o(mo), .main_output_oe_n_o(mo_oe_n), .divided_output_o(dvo),
        .divided_output_oe_n_o(dvo_oe_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Host keeps both dividers in 3..127 and reserved bits high
    function automatic logic [23:0] legal(input logic [23:0] v);
        if (v[6:0] < 7'h03) v[6:0] = 7'h03;
        if (v[13:7] < 7'h03) v[13:7] = 7'h03;
        v[21] = 1'b1;
        v[23] = 1'b1;
        return v;
    endfunction
    function automatic logic [1:0] oe_exp(input logic p, input logic [23:0] v);
        return {~(p & v[19]), ~(p & v[20])};
    endfunction
    // Main output period in cycles: oscillator toggles every cycle, reference every third
    function automatic int main_period(input logic [23:0] v);
        return v[22] ? 6 : (2 << v[18:17]);
    endfunction
    // Edge counts over a window may be off by one from the phase at its start
    function automatic logic near(input int got, input int exp);
        return (got + 1 >= exp) && (got <= exp + 1);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        osc <= ~osc;
        rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
        if (rdiv == 2'h2) refl <= ~refl;
    end
    always @(posedge clk) begin
        cycles++;
        if (commit === 1'b1) commits++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        arst_n = 1'b0;
        pin = 1'b1;
        osc = 1'b0;
        refl = 1'b0;
        rdiv = 2'h0;
        rng = 32'hd08a;
        repeat (8) @(negedge clk);
        `CHK(cfg_w, sfs_pkg::PRESET_WORD_A)
        `CHK({mo_oe_n, dvo_oe_n, busy, bit_count}, 8'he0)
        arst_n = 1'b1;
        exp_w = sfs_pkg::PRESET_WORD_A;
        repeat (4) @(negedge clk);
        `CHK(busy, 1'b1)
        for (i = 0; i < 10; i++) begin
            rng = xs(rng);
            w = legal(rng[23:0]);
            keep = 24;
            case (i)
                1: keep = 23;
                2: keep = 26;
                3: w[22] = 1'b1;
                4: w = legal(24'h000000);
                5: keep = 0;
                6: w[18:17] = 2'h1;
                default: ;
            endcase
            c0 = commits;
            host.send(w, keep);
            if (keep >= 24) exp_w = w;
            `CHK(cfg_w, exp_w)
            `CHK(commits, c0 + ((keep >= 24) ? 1 : 0))
            `CHK(bit_count, 5'h00)
            `CHK(busy, keep == 24)
            pin = rng[31];
            repeat (5) @(negedge clk);
            `CHK({mo_oe_n, dvo_oe_n}, oe_exp(pin, exp_w))
            mr = 0;
            dr = 0;
            mo_q = mo;
            dvo_q = dvo;
            repeat (96) begin
                @(negedge clk);
                if (mo && !mo_q) mr++;
                if (dvo && !dvo_q) dr++;
                mo_q = mo;
                dvo_q = dvo;
            end
            `CHK(near(mr, 96 / main_period(exp_w)), 1'b1)
            `CHK(near(dr, 96 / (main_period(exp_w) << exp_w[16:15])), 1'b1)
            `CHK(busy, 1'b0)
        end
        tally_and_finish();
    end
endmodule
